//--- hw/t1tpg_fifo2.sv
// Small valid/ready buffer; read data is muxed from storage by the read pointer, with no output register
`timescale 1ns/10ps
module t1tpg_fifo2 #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_ce,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push;
  wire              pop;

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign push        = i_ce & i_in_valid & o_in_ready;
  assign pop         = i_ce & o_out_valid & i_out_ready;
  assign o_out_data  = mem_q[rd_q];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage carries no reset; only occupied slots are ever read
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

endmodule // t1tpg_fifo2

//--- hw/t1tpg_gen.sv
// T1 test pattern generator: pattern sources, framing insertion, output buffer
`timescale 1ns/10ps

// Overview of operation
// - 2^15-1 pseudo-random, 32767-bit period
// - 2^23-1 pseudo-random, 8388607-bit period
// - All ones sends continuous one bits
// - Framed all zeros: framing bit, zero payload
// - 3-in-24 word, longest zero run 15
// - 2-in-8 repeats 0100 0010, framed alike
// - 1-in-8 word differs framed versus unframed
// - Daly 55 octets; framing bits inserted, not overwriting
// - User word up to 32 bits repeated
// - QRS 20-stage, taps 17/20, ones-forcing
// - Unframed, framing-bit-only, SF, ESF framing choices
module t1tpg_gen #(
  parameter int unsigned         BUF_DEPTH    = 2,
  parameter logic [8*55-1:0]     DALY_PATTERN = {{27{8'h01}}, {28{8'hFF}}}
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire logic                  i_ce,
  // Configuration
  input  wire t1tpg_pkg::t1tpg_cfg_t i_cfg,
  // Line stream
  output logic                       o_valid,
  input  wire logic                  i_ready,
  output t1tpg_pkg::t1tpg_sym_t      o_sym
);

  // Configuration tracking
  t1tpg_pkg::t1tpg_cfg_t cfg_q;
  logic                  run_q;
  wire                   restart;
  wire                   buf_ready;
  wire                   advance;

  // Framing state
  logic [7:0]            slot_q;
  logic [7:0]            slot_d;
  logic [4:0]            mf_q;
  logic [4:0]            mf_d;
  wire                   slot_wrap;
  wire [4:0]             mf_last;
  wire                   mf_wrap;
  t1tpg_pkg::t1tpg_fmt_t fmt_eff;
  wire                   framed;
  wire                   frame_slot;
  wire                   fbit_fbo;
  wire                   fbit_sf;
  wire                   fbit_esf;
  wire                   esf_fps_frame;
  wire [2:0]             esf_fps_idx;
  logic                  fbit;

  // Pattern state
  logic [19:0]           qrs_q;
  logic [14:0]           p15_q;
  logic [22:0]           p23_q;
  logic [8:0]            idx_q;
  logic [8:0]            idx_d;
  logic [8:0]            pat_len;
  wire [8:0]             idx_rev;
  wire                   payload_adv;
  wire                   qrs_bit;
  wire                   p15_bit;
  wire                   p23_bit;
  wire                   w3_bit;
  wire                   w2_bit;
  wire                   w1_bit;
  wire                   daly_bit;
  wire                   user_bit;
  wire [8:0]             user_len9;
  logic                  pat_bit;
  t1tpg_pkg::t1tpg_sym_t sym;

  // Any configuration edit restarts the sequence from its seed
  assign restart     = run_q && (i_cfg != cfg_q);
  assign advance     = i_ce & run_q & buf_ready & ~restart;

  // All-zeros always carries framing, even with unframed chosen
  assign fmt_eff     = ((i_cfg.pattern == t1tpg_pkg::PAT_ZEROS) &&
                        (i_cfg.fmt == t1tpg_pkg::FMT_UNFRAMED)) ?
                       t1tpg_pkg::FMT_FRAMING_BIT_ONLY_FORMAT : i_cfg.fmt;
  assign framed      = (fmt_eff != t1tpg_pkg::FMT_UNFRAMED);
  assign frame_slot  = framed && (slot_q == 8'h00);
  // Payload only advances off the framing slot, so no bit is overwritten
  assign payload_adv = advance & ~frame_slot;

  // Frame and multiframe counters
  assign slot_wrap   = (slot_q == t1tpg_pkg::FRAME_LAST);
  assign mf_last     = (fmt_eff == t1tpg_pkg::FMT_SUPERFRAME)     ? t1tpg_pkg::MF_LAST_SF  :
                       (fmt_eff == t1tpg_pkg::FMT_EXT_SUPERFRAME) ? t1tpg_pkg::MF_LAST_ESF :
                                                                    t1tpg_pkg::MF_LAST_FBO;
  assign mf_wrap     = (mf_q >= mf_last);
  assign slot_d      = slot_wrap ? 8'h00 : slot_q + 8'h01;
  assign mf_d        = !slot_wrap ? mf_q : (mf_wrap ? 5'h00 : mf_q + 5'h01);

  // Framing bit values per format
  assign fbit_fbo      = ~mf_q[0];
  assign fbit_sf       = t1tpg_pkg::SF_FBITS[4'(5'd11 - mf_q)];
  assign esf_fps_frame = (mf_q[1:0] == 2'h3);
  assign esf_fps_idx   = 3'(5'd5 - (mf_q >> 2));
  // Non-FPS ESF bits idle at one; no CRC or data link is generated
  assign fbit_esf      = esf_fps_frame ? t1tpg_pkg::ESF_FPS[esf_fps_idx] : 1'b1;

  always_comb begin
    case (fmt_eff)
      t1tpg_pkg::FMT_FRAMING_BIT_ONLY_FORMAT: fbit = fbit_fbo;
      t1tpg_pkg::FMT_SUPERFRAME:              fbit = fbit_sf;
      t1tpg_pkg::FMT_EXT_SUPERFRAME:          fbit = fbit_esf;
      default:                                fbit = 1'b0;
    endcase
  end

  // Pseudo-random sources, output from the last stage
  assign qrs_bit  = (qrs_q[18:5] == 14'h0000) ? 1'b1 : qrs_q[19];
  assign p15_bit  = p15_q[14];
  assign p23_bit  = p23_q[22];

  // Word sources, most significant bit first
  assign user_len9 = (i_cfg.user_len == 6'h00 || i_cfg.user_len > 6'h20) ?
                     t1tpg_pkg::LEN_USER_MAX : {3'h0, i_cfg.user_len};
  always_comb begin
    case (i_cfg.pattern)
      t1tpg_pkg::PAT_3IN24: pat_len = t1tpg_pkg::LEN_3IN24;
      t1tpg_pkg::PAT_2IN8:  pat_len = t1tpg_pkg::LEN_16;
      t1tpg_pkg::PAT_1IN8:  pat_len = t1tpg_pkg::LEN_16;
      t1tpg_pkg::PAT_DALY:  pat_len = t1tpg_pkg::LEN_DALY;
      t1tpg_pkg::PAT_USER:  pat_len = user_len9;
      default:              pat_len = t1tpg_pkg::LEN_ONE;
    endcase
  end
  assign idx_rev  = pat_len - 9'h001 - idx_q;
  assign w3_bit   = t1tpg_pkg::W_3IN24[idx_rev[4:0]];
  assign w2_bit   = t1tpg_pkg::W_2IN8[idx_rev[3:0]];
  assign w1_bit   = framed ? t1tpg_pkg::W_1IN8_FR[idx_rev[3:0]] :
                             t1tpg_pkg::W_1IN8_UNF[idx_rev[3:0]];
  assign daly_bit = DALY_PATTERN[idx_rev];
  assign user_bit = i_cfg.user_word[idx_rev[4:0]];
  // Out-of-range index after a length edit folds back to zero
  assign idx_d    = (idx_q >= pat_len - 9'h001) ? 9'h000 : idx_q + 9'h001;

  always_comb begin
    case (i_cfg.pattern)
      t1tpg_pkg::PAT_QRS:    pat_bit = qrs_bit;
      t1tpg_pkg::PAT_PRBS15: pat_bit = p15_bit;
      t1tpg_pkg::PAT_PRBS23: pat_bit = p23_bit;
      t1tpg_pkg::PAT_ONES:   pat_bit = 1'b1;
      t1tpg_pkg::PAT_ZEROS:  pat_bit = 1'b0;
      t1tpg_pkg::PAT_3IN24:  pat_bit = w3_bit;
      t1tpg_pkg::PAT_2IN8:   pat_bit = w2_bit;
      t1tpg_pkg::PAT_1IN8:   pat_bit = w1_bit;
      t1tpg_pkg::PAT_DALY:   pat_bit = daly_bit;
      t1tpg_pkg::PAT_USER:   pat_bit = user_bit;
      default:               pat_bit = 1'b0;
    endcase
  end

  assign sym.frame_bit = frame_slot;
  assign sym.line_bit  = frame_slot ? fbit : pat_bit;

  // Configuration capture and start-up
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cfg_q <= '0;
      run_q <= 1'b0;
    end else if (i_ce) begin
      cfg_q <= i_cfg;
      run_q <= 1'b1;
    end
  end

  // Framing counters; restart realigns to the framing slot
  always_ff @(posedge i_clk) begin
    if (i_srst || (i_ce && restart)) begin
      slot_q <= 8'h00;
      mf_q   <= 5'h00;
    end else if (advance) begin
      slot_q <= slot_d;
      mf_q   <= mf_d;
    end
  end

  // Shift registers reseeded on reset and on any pattern change
  always_ff @(posedge i_clk) begin
    if (i_srst || (i_ce && restart) || !run_q) begin
      qrs_q <= t1tpg_pkg::QRS_SEED;
      p15_q <= t1tpg_pkg::P15_SEED;
      p23_q <= t1tpg_pkg::P23_SEED;
      idx_q <= 9'h000;
    end else if (payload_adv) begin
      qrs_q <= {qrs_q[18:0], qrs_q[16] ^ qrs_q[19]};
      p15_q <= {p15_q[13:0], p15_q[14] ^ p15_q[13]};
      p23_q <= {p23_q[21:0], p23_q[22] ^ p23_q[17]};
      idx_q <= idx_d;
    end
  end

  // Two-entry buffer so a receiver stall loses no bit
  t1tpg_fifo2 #(
    .WIDTH (2),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_ce        (i_ce),
    .i_in_valid  (run_q & ~restart),
    .o_in_ready  (buf_ready),
    .i_in_data   (sym),
    .o_out_valid (o_valid),
    .i_out_ready (i_ready),
    .o_out_data  (o_sym)
  );

endmodule // t1tpg_gen

//--- shared/t1tpg_pkg.sv
// Constants, enumerations and carrier types for the T1 test pattern generator
package t1tpg_pkg;

  // Pattern selections
  typedef enum logic [3:0] {
    PAT_QRS      = 4'h0,
    PAT_PRBS15   = 4'h1,
    PAT_PRBS23   = 4'h2,
    PAT_ONES     = 4'h3,
    PAT_ZEROS    = 4'h4,
    PAT_3IN24    = 4'h5,
    PAT_2IN8     = 4'h6,
    PAT_1IN8     = 4'h7,
    PAT_DALY     = 4'h8,
    PAT_USER     = 4'h9
  } t1tpg_pat_t;

  // Framing selections
  typedef enum logic [1:0] {
    FMT_UNFRAMED                 = 2'h0,
    FMT_FRAMING_BIT_ONLY_FORMAT  = 2'h1,
    FMT_SUPERFRAME               = 2'h2,
    FMT_EXT_SUPERFRAME           = 2'h3
  } t1tpg_fmt_t;

  // Operator configuration
  typedef struct packed {
    t1tpg_pat_t  pattern;
    t1tpg_fmt_t  fmt;
    logic [31:0] user_word;
    logic [5:0]  user_len;
  } t1tpg_cfg_t;

  // One line symbol
  typedef struct packed {
    logic line_bit;
    logic frame_bit;
  } t1tpg_sym_t;

  // Pseudo-random generators
  localparam int unsigned QRS_STAGES   = 20;
  localparam int unsigned QRS_TAP      = 17;
  localparam int unsigned QRS_ZERO_RUN = 14;
  localparam int unsigned P15_STAGES   = 15;
  localparam int unsigned P15_TAP      = 14;
  localparam int unsigned P23_STAGES   = 23;
  localparam int unsigned P23_TAP      = 18;
  localparam logic [19:0] QRS_SEED     = 20'hFFFFF;
  localparam logic [14:0] P15_SEED     = 15'h7FFF;
  localparam logic [22:0] P23_SEED     = 23'h7FFFFF;

  // Fixed words, sent most significant bit first
  localparam logic [23:0] W_3IN24      = 24'h888000;
  localparam logic [15:0] W_2IN8       = 16'h4242;
  localparam logic [15:0] W_1IN8_UNF   = 16'h8080;
  localparam logic [15:0] W_1IN8_FR    = 16'h4040;
  localparam logic [8:0]  LEN_3IN24    = 9'h018;
  localparam logic [8:0]  LEN_16       = 9'h010;
  localparam logic [8:0]  LEN_USER_MAX = 9'h020;
  localparam logic [8:0]  LEN_ONE      = 9'h001;
  localparam int unsigned DALY_OCTETS  = 55;
  localparam logic [8:0]  LEN_DALY     = 9'h1B8;

  // Framing
  localparam logic [7:0]  FRAME_LAST   = 8'hC0;
  localparam logic [4:0]  MF_LAST_FBO  = 5'h01;
  localparam logic [4:0]  MF_LAST_SF   = 5'h0B;
  localparam logic [4:0]  MF_LAST_ESF  = 5'h17;
  localparam logic [11:0] SF_FBITS     = 12'h8DC;
  localparam logic [5:0]  ESF_FPS      = 6'h0B;

endpackage : t1tpg_pkg

//--- testbench/t1tpg_gen_chk.sv
// Port assertions for the T1 test pattern generator
`timescale 1ns/10ps
module t1tpg_gen_chk (
  // Clock, reset, config
  input wire logic                  i_clk,
  input wire logic                  i_srst,
  input wire logic                  i_ce,
  input wire t1tpg_pkg::t1tpg_cfg_t i_cfg,
  // Line stream
  input wire logic                  o_valid,
  input wire logic                  i_ready,
  input wire t1tpg_pkg::t1tpg_sym_t o_sym
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  t1tpg_pkg::t1tpg_cfg_t cfg_q;
  logic [3:0]            age_q;
  logic [22:0]           hist_q;
  logic [4:0]            hn_q;
  logic [4:0]            zr_q;
  logic [7:0]            pc_q;
  logic                  seen_q;
  wire                   take = i_ce && o_valid && i_ready;
  wire                   pay  = take && !o_sym.frame_bit;
  // Up to two symbols of the old selection may still sit in the buffer;
  // the edit cycle itself still shows an old symbol against the new selection
  wire                   stale = (age_q < 4'h4) || (i_cfg != cfg_q);
  wire                   lb = o_sym.line_bit;
  always_ff @(posedge i_clk) begin
    cfg_q <= i_cfg;
    if (i_srst || i_cfg != cfg_q) begin
      age_q <= 4'h0;
      hn_q <= 5'h00;
      zr_q <= 5'h00;
      seen_q <= 1'b0;
    end else if (take) begin
      age_q <= age_q + {3'h0, age_q != 4'hF};
      pc_q <= o_sym.frame_bit ? 8'h00 : pc_q + 8'h01;
      if (o_sym.frame_bit && !stale) seen_q <= 1'b1;
      if (pay && !stale) begin
        hist_q <= {hist_q[21:0], lb};
        hn_q <= hn_q + {4'h0, hn_q != 5'h17};
        zr_q <= lb ? 5'h00 : zr_q + 5'h01;
      end
    end
  end
  frame_gap_a: assert property (take && o_sym.frame_bit && seen_q |-> pc_q == 8'hC0)
    else $error("frame spacing wrong");
  prbs15_a: assert property (pay && !stale && hn_q == 5'h17 && i_cfg.pattern ==
    t1tpg_pkg::PAT_PRBS15 |-> lb == (hist_q[13] ^ hist_q[14])) else $error("prbs15 bit wrong");
  prbs23_a: assert property (pay && !stale && hn_q == 5'h17 && i_cfg.pattern ==
    t1tpg_pkg::PAT_PRBS23 |-> lb == (hist_q[17] ^ hist_q[22])) else $error("prbs23 bit wrong");
  zero_run_a: assert property (!stale && (i_cfg.pattern == t1tpg_pkg::PAT_QRS ||
    i_cfg.pattern == t1tpg_pkg::PAT_PRBS15) |-> zr_q <= 5'h0E) else $error("zero run too long");
  ones_a: assert property (pay && !stale && i_cfg.pattern == t1tpg_pkg::PAT_ONES |-> lb)
    else $error("ones pattern bit low");
  zeros_a: assert property (pay && !stale && i_cfg.pattern == t1tpg_pkg::PAT_ZEROS |-> !lb)
    else $error("zeros payload bit high");
  unframed_a: assert property (take && !stale && i_cfg.fmt == t1tpg_pkg::FMT_UNFRAMED &&
    i_cfg.pattern != t1tpg_pkg::PAT_ZEROS |-> !o_sym.frame_bit) else $error("unexpected frame");
  stall_hold_a: assert property (o_valid && !(i_ready && i_ce) |=> o_valid && $stable(o_sym))
    else $error("symbol lost in stall");
  start_a: assert property ($fell(i_srst) && i_ce |-> ##[0:3] o_valid)
    else $error("no output after reset");
  cover property (take && o_sym.frame_bit && seen_q);
  cover property (pay && hn_q == 5'h17 && i_cfg.pattern == t1tpg_pkg::PAT_PRBS23);
  cover property (o_valid && !i_ready);
endmodule // t1tpg_gen_chk

bind t1tpg_gen t1tpg_gen_chk i_t1tpg_gen_chk (.i_clk, .i_srst, .i_ce, .i_cfg, .o_valid,
  .i_ready, .o_sym);

//--- testbench/t1tpg_line_sink.sv
// Line receiver model: takes symbols, may stall
`timescale 1ns/10ps
module t1tpg_line_sink (
  // Clock
  input wire logic                  i_clk,
  input wire logic                  i_ce,
  // Stream from generator
  input wire logic                  i_valid,
  output logic                      o_ready,
  input wire t1tpg_pkg::t1tpg_sym_t i_sym,
  // Slow mode takes one cycle in three
  input wire logic                  i_slow
);
  t1tpg_pkg::t1tpg_sym_t rx[$];
  logic [1:0]            ph_q = 2'h0;
  assign o_ready = !i_slow || ph_q == 2'h0;
  always @(posedge i_clk) begin
    ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    if (i_ce && i_valid && o_ready) rx.push_back(i_sym);
  end
endmodule // t1tpg_line_sink

//--- testbench/tb_t1tpg_gen.sv
// Self-checking bench for the T1 test pattern generator
`timescale 1ns/10ps
module tb_t1tpg_gen;
  logic                  i_clk = 1'b0;
  logic                  i_srst = 1'b1;
  logic                  i_ce = 1'b1;
  logic                  slow = 1'b0;
  logic                  ce_gap = 1'b0;
  t1tpg_pkg::t1tpg_cfg_t i_cfg = '0;
  logic                  o_valid;
  logic                  i_ready;
  t1tpg_pkg::t1tpg_sym_t o_sym;
  int                    failures = 0;
  int                    tests_run = 0;
  int                    cyc = 0;
  logic                  pb[$];
  always #20 i_clk = ~i_clk;
  always @(negedge i_clk) i_ce <= !ce_gap || !i_ce;
  t1tpg_gen i_t1tpg_gen (.i_clk, .i_srst, .i_ce, .i_cfg, .o_valid, .i_ready, .o_sym);
  t1tpg_line_sink i_t1tpg_line_sink (.i_clk, .i_ce, .i_valid(o_valid), .o_ready(i_ready),
    .i_sym(o_sym), .i_slow(slow));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Generous ceiling; the whole run needs some 11500 cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      finish_test();
    end
  end
  // Select, drop older symbols, gather n, check framing and payload word
  task automatic scen(input t1tpg_pkg::t1tpg_pat_t p, input t1tpg_pkg::t1tpg_fmt_t f,
    input logic [31:0] uw, input logic [5:0] ul, input int n, input logic [31:0] ew,
    input int el);
    t1tpg_pkg::t1tpg_sym_t q[$];
    int fi;
    int fc;
    int ok;
    fi = -1;
    fc = 0;
    ok = 0;
    i_cfg = '{p, f, uw, ul};
    repeat (24) @(negedge i_clk);
    i_t1tpg_line_sink.rx.delete();
    while (i_t1tpg_line_sink.rx.size() < n) @(negedge i_clk);
    q = i_t1tpg_line_sink.rx;
    pb.delete();
    foreach (q[k]) begin
      if (q[k].frame_bit) begin
        if (fi >= 0) chk("frame gap", k - fi, 193);
        fi = k;
        fc++;
      end else begin
        pb.push_back(q[k].line_bit);
      end
    end
    chk("frames seen", fc > 1, f != 0 || p == t1tpg_pkg::PAT_ZEROS);
    for (int o = 0; o < el; o++) begin
      fi = 0;
      foreach (pb[i]) if (pb[i] !== ew[el - 1 - ((i + o) % el)]) fi++;
      if (fi == 0) ok = 1;
    end
    if (el > 0) chk("payload word", ok, 1);
  endtask
  task automatic t_ones();
    scen(t1tpg_pkg::PAT_ONES, t1tpg_pkg::FMT_UNFRAMED, 0, 0, 64, 1, 1);
  endtask
  task automatic t_zeros();
    for (int f = 0; f < 4; f++) scen(t1tpg_pkg::PAT_ZEROS, t1tpg_pkg::t1tpg_fmt_t'(f), 0, 0,
      500, 0, 1);
  endtask
  task automatic t_words();
    scen(t1tpg_pkg::PAT_2IN8, t1tpg_pkg::FMT_UNFRAMED, 0, 0, 420, 32'h4242, 16);
    scen(t1tpg_pkg::PAT_2IN8, t1tpg_pkg::FMT_SUPERFRAME, 0, 0, 420, 32'h4242, 16);
    scen(t1tpg_pkg::PAT_1IN8, t1tpg_pkg::FMT_UNFRAMED, 0, 0, 420, 32'h8080, 16);
    scen(t1tpg_pkg::PAT_1IN8, t1tpg_pkg::FMT_EXT_SUPERFRAME, 0, 0, 420, 32'h4040, 16);
    scen(t1tpg_pkg::PAT_3IN24, t1tpg_pkg::FMT_UNFRAMED, 0, 0, 420, 32'h888000, 24);
    scen(t1tpg_pkg::PAT_USER, t1tpg_pkg::FMT_UNFRAMED, 32'hF00D0C1B, 6'h00, 200,
      32'hF00D0C1B, 32);
  endtask
  task automatic t_daly();
    int bad;
    for (int f = 0; f < 4; f += 3) begin
      bad = 0;
      scen(t1tpg_pkg::PAT_DALY, t1tpg_pkg::t1tpg_fmt_t'(f), 0, 0, 1100, 0, 0);
      for (int i = 440; i < pb.size(); i++) if (pb[i] !== pb[i - 440]) bad++;
      chk("octet pattern period", bad, 0);
    end
  endtask
  task automatic t_prbs();
    int ones;
    for (int p = 0; p < 3; p++) begin
      scen(t1tpg_pkg::t1tpg_pat_t'(p), t1tpg_pkg::t1tpg_fmt_t'(p), 0, 0, 600, 0, 0);
      ones = pb.sum() with (int'(item));
      chk("random mix", ones > 0 && ones < pb.size(), 1);
    end
  endtask
  // Slow receiver and gated clock enable must not drop or repeat a bit
  task automatic t_stall();
    slow = 1'b1;
    ce_gap = 1'b1;
    scen(t1tpg_pkg::PAT_USER, t1tpg_pkg::FMT_FRAMING_BIT_ONLY_FORMAT, 32'h5B, 6'h07, 450,
      32'h5B, 7);
    slow = 1'b0;
    ce_gap = 1'b0;
  endtask
  initial begin
    repeat (12) @(negedge i_clk);
    i_srst = 1'b0;
    t_ones();
    t_zeros();
    t_words();
    t_daly();
    t_prbs();
    t_stall();
    finish_test();
  end
endmodule // tb_t1tpg_gen
